// *** shared/irq_pkg.sv ***
package irq_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [11:0] CFG_OFFSET    = 12'h0C8;
    localparam logic [11:0] STATUS_OFFSET = 12'h0CC;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  CFG_USED_MASK = 8'h70;
    localparam int          GEN_BIT       = 4;
    localparam int          POL2_BIT      = 5;
    localparam int          LVL1_BIT      = 6;

    // ********************************************************
    // status register fields
    // ********************************************************
    localparam int ST_PORT_A_LSB = 0;
    localparam int ST_PORT_B_LSB = 8;
    localparam int ST_TIMER_BIT  = 16;
    localparam int ST_CONV_BIT   = 17;
    localparam int ST_NMI_BIT    = 18;
    localparam int ST_SRC1_BIT   = 19;
    localparam int ST_SRC2_BIT   = 20;
    localparam int ST_MODE_LSB   = 21;
    localparam int ST_FSEL_LSB   = 23;

    // ********************************************************
    // vector table
    // ********************************************************
    localparam logic [11:0] VEC_SRC0 = 12'hFFC;
    localparam logic [11:0] VEC_SRC1 = 12'hFF6;
    localparam logic [11:0] VEC_SRC2 = 12'hFF4;
    localparam logic [11:0] VEC_SRC3 = 12'hFF2;
    localparam logic [11:0] VEC_SRC4 = 12'hFF0;
    localparam logic [11:0] VEC_RESET = 12'h000;

    // ********************************************************
    // modes and flag sets
    // ********************************************************
    typedef enum logic [1:0] {MODE_NORMAL, MODE_IRQ, MODE_NMI} mode_t;
    localparam logic [1:0] FS_NORMAL = 2'h0;
    localparam logic [1:0] FS_IRQ    = 2'h1;
    localparam logic [1:0] FS_NMI    = 2'h2;
    localparam int         SYNC_STAGES = 2;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             ref_clk, // core clock
    input  wire logic             rst,     // async reset, active high
    input  wire logic [WIDTH-1:0] async_in, // pin levels
    output logic      [WIDTH-1:0] sync_out  // levels after two flops
);
    logic [WIDTH-1:0] stage1;

    // pins idle high, so reset to the released level
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1   <= '1;
            sync_out <= '1;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** rtl/fixed_priority_interrupt_unit.sv ***
// Operation
// - nmi has top priority and preempts; maskable sources never nest.
// - pending maskable requests granted in fixed order, source one first.
// - each source has its own fixed vector address.
// - accepted request loads the program counter with its vector.
// - global enable bit 4 gates all maskable sources, never the nmi.
// - with global enable low, no source wakes the core from stop/wait.
// - nmi request held in a flip-flop cleared when its service starts.
// - source one level sensitive when bit 6 set, else falling edge.
// - source two always edge; bit 5 picks rising, else falling.
// - sources three and four are level sensitive only.
// - edge latch sets on edge, clears at service start, keeps one.
// - level requests are not stored; must be present when sampled.
// - lines tested at every instruction end; accept replaces next one.
// - entry swaps flags, pushes pc, inhibits maskable, clears latch, vectors.
// - three carry/zero pairs kept and switched without software help.
// - return restores previous flag set and pops the pc.
// - config register write-only at 0C8h, no partial writes, resets 00h.
// - per-event flags stay readable so software can find the originator.
// - timer to vector 3, converter to 4, port a to 1, port b to 2.
// - request during first 3 cycles of config-clear keeps normal flags.
// - wait/stop blocked while an enabled request is pending.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module fixed_priority_interrupt_unit
(
    input  wire logic        ref_clk,        // core clock, 125 MHz
    input  wire logic        rst,            // async reset, active high
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    input  wire logic [3:0]  pstrb,          // apb byte strobes
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic        nmi_pin_n,      // nmi pin, falling edge
    input  wire logic [7:0]  port_a_pin,     // port a pin levels
    input  wire logic [7:0]  port_a_irq_en,  // port a option and data bits
    input  wire logic [7:0]  port_b_pin,     // port b pin levels
    input  wire logic [7:0]  port_b_irq_en,  // port b option and data bits
    input  wire logic        timer_zero_flag,      // timer overflow
    input  wire logic        timer_irq_enable,     // timer mask bit
    input  wire logic        conv_done_flag,       // end of conversion
    input  wire logic        converter_irq_enable, // converter mask bit
    input  wire logic        instr_end,      // pulse: instruction completes
    input  wire logic        return_from_interrupt, // pulse: return executes
    input  wire logic        cfg_clear_early, // first 3 cycles of cfg clear
    input  wire logic        core_idle,      // core sits in stop or wait
    input  wire logic        alu_flag_we,    // write carry/zero
    input  wire logic        alu_carry,      // new carry
    input  wire logic        alu_zero,       // new zero
    output logic             svc_start,      // pulse: service entry
    output logic [11:0]      svc_vector,     // vector loaded into pc
    output logic             push_pc,        // pulse: push pc on stack
    output logic             pop_pc,         // pulse: pop pc from stack
    output logic             wake,           // level: leave stop/wait
    output logic             idle_block,     // level: refuse stop/wait
    output logic             carry,          // active carry flag
    output logic             zero            // active zero flag
);

    // ********************************************************
    // input synchronisers
    // ********************************************************
    logic [16:0] pins_sync;

    pin_sync #(.WIDTH(17)) u_sync
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({nmi_pin_n, port_b_pin, port_a_pin}),
        .sync_out (pins_sync)
    );

    logic [7:0] pa_lvl;
    logic [7:0] pb_lvl;
    logic       nmi_lvl;
    assign pa_lvl  = pins_sync[7:0];
    assign pb_lvl  = pins_sync[15:8];
    assign nmi_lvl = pins_sync[16];

    // ********************************************************
    // configuration register
    // ********************************************************
    logic [7:0] cfg;
    logic       wr_acc;
    logic       setup;
    logic       hit_cfg;
    logic       hit_st;

    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && pready;
    assign hit_cfg = (paddr == irq_pkg::CFG_OFFSET);
    assign hit_st  = (paddr == irq_pkg::STATUS_OFFSET);

    // a write without the lane-0 strobe counts as a bit operation and is refused
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cfg <= irq_pkg::CFG_RESET;
        else if (wr_acc && hit_cfg && pstrb[0])
            cfg <= pwdata[7:0] & irq_pkg::CFG_USED_MASK;
    end

    logic gen;
    logic pol2_rise;
    logic lvl1;
    assign gen       = cfg[irq_pkg::GEN_BIT];
    assign pol2_rise = cfg[irq_pkg::POL2_BIT];
    assign lvl1      = cfg[irq_pkg::LVL1_BIT];

    // ********************************************************
    // source lines
    // ********************************************************
    // lines are active low: any enabled pin pulled low asserts it
    logic line1_n;
    logic line2_n;
    logic line1_prev;
    logic line2_prev;
    logic nmi_prev;
    logic src3_req;
    logic src4_req;

    assign line1_n  = ~|(port_a_irq_en & ~pa_lvl);
    assign line2_n  = ~|(port_b_irq_en & ~pb_lvl);
    assign src3_req = timer_zero_flag && timer_irq_enable;
    assign src4_req = conv_done_flag && converter_irq_enable;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            line1_prev <= 1'b1;
            line2_prev <= 1'b1;
            nmi_prev   <= 1'b1;
        end
        else
        begin
            line1_prev <= line1_n;
            line2_prev <= line2_n;
            nmi_prev   <= nmi_lvl;
        end
    end

    logic fall1;
    logic edge2;
    logic nmi_fall;
    assign fall1    = line1_prev && !line1_n;
    assign edge2    = pol2_rise ? (!line2_prev && line2_n)
                                : (line2_prev && !line2_n);
    assign nmi_fall = nmi_prev && !nmi_lvl;

    // ********************************************************
    // request latches and arbitration
    // ********************************************************
    irq_pkg::mode_t mode;
    logic           nmi_latch;
    logic           src1_latch;
    logic           src2_latch;
    logic           src1_req;
    logic           src2_req;
    logic           mask_ok;
    logic           take_nmi;
    logic           take_mask;
    logic           take;
    logic [11:0]    next_vector;

    // level requests are only looked at, never stored
    assign src1_req  = lvl1 ? !line1_n : src1_latch;
    assign src2_req  = src2_latch;
    assign mask_ok   = gen && (mode == irq_pkg::MODE_NORMAL);
    assign take_nmi  = instr_end && nmi_latch
                       && (mode != irq_pkg::MODE_NMI);
    assign take_mask = instr_end && mask_ok && !take_nmi
                       && (src1_req || src2_req
                           || src3_req || src4_req);
    assign take      = take_nmi || take_mask;

    always_comb
    begin
        next_vector = irq_pkg::VEC_SRC4;
        if (take_nmi)
            next_vector = irq_pkg::VEC_SRC0;
        else if (src1_req)
            next_vector = irq_pkg::VEC_SRC1;
        else if (src2_req)
            next_vector = irq_pkg::VEC_SRC2;
        else if (src3_req)
            next_vector = irq_pkg::VEC_SRC3;
    end

    logic clr1;
    logic clr2;
    assign clr1 = take_mask && (next_vector == irq_pkg::VEC_SRC1);
    assign clr2 = take_mask && (next_vector == irq_pkg::VEC_SRC2);

    // a new edge in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            nmi_latch  <= 1'b0;
            src1_latch <= 1'b0;
            src2_latch <= 1'b0;
        end
        else
        begin
            nmi_latch  <= nmi_fall || (nmi_latch && !take_nmi);
            src1_latch <= (fall1 && !lvl1)
                          || (src1_latch && !clr1);
            src2_latch <= edge2 || (src2_latch && !clr2);
        end
    end

    // ********************************************************
    // mode and flag set sequencing
    // ********************************************************
    irq_pkg::mode_t nmi_ret_mode;
    logic [1:0]     flag_sel;
    logic [1:0]     nmi_ret_sel;
    logic           keep_flags;

    // a request seen while config is being cleared leaves flags as they were
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            keep_flags <= 1'b0;
        else if (instr_end)
            keep_flags <= 1'b0;
        else if (cfg_clear_early && gen
                 && (mode == irq_pkg::MODE_NORMAL)
                 && (src1_req || src2_req || src3_req || src4_req))
            keep_flags <= 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mode         <= irq_pkg::MODE_NORMAL;
            flag_sel     <= irq_pkg::FS_NORMAL;
            nmi_ret_mode <= irq_pkg::MODE_NORMAL;
            nmi_ret_sel  <= irq_pkg::FS_NORMAL;
        end
        else if (take_nmi)
        begin
            nmi_ret_mode <= mode;
            nmi_ret_sel  <= flag_sel;
            mode         <= irq_pkg::MODE_NMI;
            flag_sel     <= irq_pkg::FS_NMI;
        end
        else if (take_mask)
        begin
            mode <= irq_pkg::MODE_IRQ;
            if (!keep_flags)
                flag_sel <= irq_pkg::FS_IRQ;
        end
        else if (return_from_interrupt)
        begin
            case (mode)
                irq_pkg::MODE_NMI:
                begin
                    mode     <= nmi_ret_mode;
                    flag_sel <= nmi_ret_sel;
                end
                irq_pkg::MODE_IRQ:
                begin
                    mode     <= irq_pkg::MODE_NORMAL;
                    flag_sel <= irq_pkg::FS_NORMAL;
                end
                default:
                    mode <= mode;
            endcase
        end
    end

    // ********************************************************
    // core handshake outputs
    // ********************************************************
    logic any_enabled;
    assign any_enabled = nmi_latch || (mask_ok && (src1_req || src2_req
                                       || src3_req || src4_req));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            svc_start  <= 1'b0;
            push_pc    <= 1'b0;
            pop_pc     <= 1'b0;
            svc_vector <= irq_pkg::VEC_RESET;
            wake       <= 1'b0;
            idle_block <= 1'b0;
        end
        else
        begin
            svc_start  <= take;
            push_pc    <= take;
            pop_pc     <= return_from_interrupt && !take
                          && (mode != irq_pkg::MODE_NORMAL);
            if (take)
                svc_vector <= next_vector;
            // gen low also silences the nmi as a wake source
            wake       <= core_idle && gen && any_enabled;
            idle_block <= any_enabled;
        end
    end

    // ********************************************************
    // carry and zero flag pairs
    // ********************************************************
    logic [2:0] c_set;
    logic [2:0] z_set;
    logic [1:0] next_sel;
    assign next_sel = take_nmi ? irq_pkg::FS_NMI
                    : (take_mask && !keep_flags) ? irq_pkg::FS_IRQ
                    : (return_from_interrupt
                       && mode == irq_pkg::MODE_NMI) ? nmi_ret_sel
                    : (return_from_interrupt
                       && mode == irq_pkg::MODE_IRQ) ? irq_pkg::FS_NORMAL
                    : flag_sel;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            c_set <= 3'h0;
            z_set <= 3'h0;
            carry <= 1'b0;
            zero  <= 1'b0;
        end
        else
        begin
            if (alu_flag_we)
            begin
                c_set[flag_sel] <= alu_carry;
                z_set[flag_sel] <= alu_zero;
            end
            if (alu_flag_we && next_sel == flag_sel)
            begin
                carry <= alu_carry;
                zero  <= alu_zero;
            end
            else
            begin
                carry <= c_set[next_sel];
                zero  <= z_set[next_sel];
            end
        end
    end

    // ********************************************************
    // apb slave
    // ********************************************************
    logic [31:0] status;
    always_comb
    begin
        status = 32'h0000_0000;
        status[irq_pkg::ST_PORT_A_LSB +: 8] = pa_lvl;
        status[irq_pkg::ST_PORT_B_LSB +: 8] = pb_lvl;
        status[irq_pkg::ST_TIMER_BIT]       = timer_zero_flag;
        status[irq_pkg::ST_CONV_BIT]        = conv_done_flag;
        status[irq_pkg::ST_NMI_BIT]         = nmi_latch;
        status[irq_pkg::ST_SRC1_BIT]        = src1_latch;
        status[irq_pkg::ST_SRC2_BIT]        = src2_latch;
        status[irq_pkg::ST_MODE_LSB +: 2]   = mode;
        status[irq_pkg::ST_FSEL_LSB +: 2]   = flag_sel;
    end

    // answers are prepared in the setup cycle, so access never waits
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (setup)
            begin
                prdata  <= (!pwrite && hit_st) ? status : 32'h0000_0000;
                pslverr <= !(hit_cfg || hit_st)
                           || (pwrite && hit_st)
                           || (pwrite && !pstrb[0]);
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    a_nmi_no_mask: assert property (@(posedge ref_clk) disable iff (rst)
        (svc_start && mode == irq_pkg::MODE_IRQ)
        |-> $past(mode) == irq_pkg::MODE_NORMAL)
        else $error("maskable source nested");
    a_prio_fixed: assert property (@(posedge ref_clk) disable iff (rst)
        (svc_start && svc_vector == irq_pkg::VEC_SRC2) |-> !$past(src1_req))
        else $error("source two beat source one");
    a_nmi_vector: assert property (@(posedge ref_clk) disable iff (rst)
        svc_start |-> ((svc_vector == irq_pkg::VEC_SRC0)
                       == (mode == irq_pkg::MODE_NMI)))
        else $error("vector does not match mode");
    a_gen_gates: assert property (@(posedge ref_clk) disable iff (rst)
        (svc_start && mode == irq_pkg::MODE_IRQ) |-> $past(gen))
        else $error("maskable taken with gen low");
    a_wake_gen: assert property (@(posedge ref_clk) disable iff (rst)
        wake |-> $past(gen) && $past(core_idle))
        else $error("wake without gen");
    a_nmi_cleared: assert property (@(posedge ref_clk) disable iff (rst)
        (take_nmi && !nmi_fall) |=> !nmi_latch)
        else $error("nmi latch not cleared");
    a_cfg_write: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_acc && hit_cfg && pstrb[0])
        |=> cfg == ($past(pwdata[7:0]) & irq_pkg::CFG_USED_MASK))
        else $error("config write lost");
    a_entry_push: assert property (@(posedge ref_clk) disable iff (rst)
        take |=> svc_start && push_pc ##1 !svc_start)
        else $error("entry sequence wrong");
    a_return_from_interrupt_pop: assert property (@(posedge ref_clk) disable iff (rst)
        (return_from_interrupt && !take && mode == irq_pkg::MODE_IRQ)
        |=> pop_pc && mode == irq_pkg::MODE_NORMAL)
        else $error("return did not restore");
    a_idle_block: assert property (@(posedge ref_clk) disable iff (rst)
        $past(nmi_latch) |-> idle_block)
        else $error("idle allowed with nmi pending");

    c_nmi_preempt: cover property (@(posedge ref_clk) disable iff (rst)
        mode == irq_pkg::MODE_IRQ ##[1:50] mode == irq_pkg::MODE_NMI);
    c_src2_taken: cover property (@(posedge ref_clk) disable iff (rst)
        svc_start && svc_vector == irq_pkg::VEC_SRC2);
    c_return_from_interrupt_back: cover property (@(posedge ref_clk) disable iff (rst)
        pop_pc && mode == irq_pkg::MODE_NORMAL);

endmodule

// *** sim/core_seq_model.sv ***
`timescale 1ns/1ps
module core_seq_model
(
    input  wire logic ref_clk,   // core clock
    input  wire logic rst,       // async reset, active high
    input  wire logic svc_start, // service entry pulse
    output logic      instr_end, // instruction boundary pulse
    output logic      ret_pulse  // return from service pulse
);
    logic [1:0] icnt;
    logic       pend;
    // ****************************************************
    // one instruction per four cycles; the return is kept
    // off the boundary, where an accept would swallow it
    // ****************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            icnt      <= 2'h0;
            instr_end <= 1'b0;
            ret_pulse <= 1'b0;
            pend      <= 1'b0;
        end
        else
        begin
            icnt      <= icnt + 2'h1;
            instr_end <= (icnt == 2'h2);
            ret_pulse <= pend && (icnt == 2'h1);
            pend      <= svc_start || (pend && icnt != 2'h1);
        end
    end
endmodule

// *** sim/fixed_priority_interrupt_unit_tb_top.sv ***
`timescale 1ns/1ps
module fixed_priority_interrupt_unit_tb_top;
    // sentinel outside the vector table: no service entry seen
    localparam logic [11:0] NONE = 12'h123;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, nmi_pin_n = 1'b1, tmr = 1'b0, conv = 1'b0;
    logic        te = 1'b0, ce = 1'b0, pready, pslverr, svc_start, ie, rf, er;
    logic [11:0] paddr = 12'h0, svc_vector, v;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0, seen;
    logic        ci = 1'b0, wk, ib, pp, po;
    logic [7:0]  pa = 8'hFF, pb = 8'hFF, pae = 8'h00, pbe = 8'h00;
    int          fail_count = 0, cmp_count = 0, seed = 32'hb626, k;
    fixed_priority_interrupt_unit dut
    (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmi_pin_n(nmi_pin_n), .port_a_pin(pa), .port_a_irq_en(pae),
        .port_b_pin(pb), .port_b_irq_en(pbe), .timer_zero_flag(tmr),
        .timer_irq_enable(te), .conv_done_flag(conv),
        .converter_irq_enable(ce), .instr_end(ie),
        .return_from_interrupt(rf), .cfg_clear_early(1'b0),
        .core_idle(ci), .alu_flag_we(1'b0), .alu_carry(1'b0),
        .alu_zero(1'b0), .svc_start(svc_start), .svc_vector(svc_vector),
        .push_pc(pp), .pop_pc(po), .wake(wk), .idle_block(ib), .carry(),
        .zero()
    );
    core_seq_model seq
    (
        .ref_clk(ref_clk), .rst(rst), .svc_start(svc_start),
        .instr_end(ie), .ret_pulse(rf)
    );
    // ****************************************************
    // bus, checking and closing tasks
    // ****************************************************
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        fail_count += (g !== e);
        if (g !== e)
            $display("ERROR %0t got %h exp %h", $time, g, e);
    endtask
    function automatic logic [11:0] exp_vec(input int s);
        return (s == 0) ? 12'hFFC : 12'hFF8 - 12'(2 * s);
    endfunction
    // only the first entry in the window counts; level sources re-enter
    task wait_chk(input logic [11:0] e);
        v = NONE;
        seen = 4'h0;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge ref_clk);
            seen = seen | {wk, ib, pp, po};
            // an entry already in flight at the call belongs to the last test
            if (n > 0 && svc_start === 1'b1 && v === NONE)
                v = svc_vector;
        end
        chk({20'h0, v}, {20'h0, e});
        $display("test vector %h done", e);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
        forever #4 ref_clk = ~ref_clk;
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h0C8, 32'h0, 4'hF);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0CC, 32'h0, 4'hF);
        chk(rd, 32'h0000_FFFF);
        apb(1'b1, 12'h0C8, 32'h0000_0010, 4'h0);
        chk({31'h0, er}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            k = $random(seed) & 7;
            apb(1'b1, 12'h0D0 + 12'(k * 4), $random(seed), 4'hF);
            chk({31'h0, er}, 32'h1);
        end
        {tmr, te, conv, ce} <= 4'hF;
        ci <= 1'b1;
        wait_chk(NONE);
        chk({28'h0, seen}, 32'h0);
        apb(1'b1, 12'h0C8, 32'h0000_0010, 4'hF);
        wait_chk(exp_vec(3));
        chk({28'h0, seen}, 32'hF);
        tmr <= 1'b0;
        wait_chk(exp_vec(4));
        conv <= 1'b0;
        nmi_pin_n <= 1'b0;
        wait_chk(exp_vec(0));
        nmi_pin_n <= 1'b1;
        wait_chk(NONE);
        k = $random(seed) & 7;
        pbe <= 8'h01 << k;
        pb  <= ~(8'h01 << k);
        wait_chk(exp_vec(2));
        pb <= 8'hFF;
        wait_chk(NONE);
        apb(1'b1, 12'h0C8, 32'h0000_0050, 4'hF);
        pae <= 8'h01 << k;
        pa  <= ~(8'h01 << k);
        wait_chk(exp_vec(1));
        tally_and_finish;
    end
endmodule
